// ---- logic/dlw_pkg.sv ----
// Package for the drive limit warning and skip band block
package dlw_pkg;

  // Fixed point scales: current in 0.1 A, frequency in 0.1 Hz, feedback in 0.001 units
  localparam int CUR_W = 16;
  localparam int FRQ_W = 16;
  localparam int FB_W = 28;

  // Register byte offsets
  localparam logic [7:0] OFS_CUR_LOW = 8'h00;
  localparam logic [7:0] OFS_CUR_HIGH = 8'h04;
  localparam logic [7:0] OFS_FRQ_LOW = 8'h08;
  localparam logic [7:0] OFS_FRQ_HIGH = 8'h0c;
  localparam logic [7:0] OFS_FB_LOW = 8'h10;
  localparam logic [7:0] OFS_FB_HIGH = 8'h14;
  localparam logic [7:0] OFS_SKIP_BW = 8'h18;
  localparam logic [7:0] OFS_SKIP_A = 8'h1c;
  localparam logic [7:0] OFS_SKIP_B = 8'h20;
  localparam logic [7:0] OFS_CONFIG = 8'h24;
  localparam logic [7:0] OFS_ROUTE_DOUT = 8'h28;
  localparam logic [7:0] OFS_ROUTE_RELAY = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_TARGET = 8'h34;

  // Reset values
  localparam logic [CUR_W-1:0] RST_CUR_LOW = 16'h0000;
  localparam logic [CUR_W-1:0] CUR_MAX_DEFAULT = 16'hffff;
  localparam logic [FRQ_W-1:0] RST_FRQ_LOW = 16'h0000;
  localparam logic [FRQ_W-1:0] RST_FRQ_HIGH = 16'h0528;
  localparam logic signed [FB_W-1:0] RST_FB_LOW = -28'sh03d0900;
  localparam logic signed [FB_W-1:0] RST_FB_HIGH = 28'sh03d0900;
  localparam logic [FRQ_W-1:0] RST_SKIP = 16'h0000;

  // Limits
  localparam logic [FRQ_W-1:0] FRQ_CAP_LOW_RANGE = 16'h0528;
  localparam logic [FRQ_W-1:0] FRQ_CAP_HIGH_RANGE = 16'h2710;
  localparam logic [FRQ_W-1:0] SKIP_BW_MAX = 16'h03e8;
  localparam logic [FRQ_W-1:0] SKIP_CENTRE_MAX = 16'h2710;

  // Config field positions
  localparam int CFG_RANGE_LSB = 0;

  // Warning bit positions
  localparam int W_CUR_LOW = 0;
  localparam int W_CUR_HIGH = 1;
  localparam int W_FRQ_LOW = 2;
  localparam int W_FRQ_HIGH = 3;
  localparam int W_FB_LOW = 4;
  localparam int W_FB_HIGH = 5;
  localparam int N_WARN = 6;

  // Supervision phases
  typedef enum logic [1:0] {
    DLW_STOPPED,
    DLW_RAMP_UP,
    DLW_AT_REF,
    DLW_RAMP_DOWN
  } dlw_phase_type;

  // Measured drive values, sampled once per control update
  typedef struct packed {
    logic [CUR_W-1:0] current;
    logic [FRQ_W-1:0] freq;
    logic signed [FB_W-1:0] feedback;
  } dlw_meas_type;

  // Drive run state
  typedef struct packed {
    logic run;
    logic [FRQ_W-1:0] reference;
  } dlw_drive_type;

endpackage

// ---- logic/dlw_top.sv ----
// Limit warnings and skip band clamp for the drive control logic
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dlw_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic update_i,
  input wire dlw_pkg::dlw_meas_type meas_i,
  input wire dlw_pkg::dlw_drive_type drive_i,
  input wire logic [dlw_pkg::CUR_W-1:0] current_max_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [dlw_pkg::N_WARN-1:0] warn_o,
  output logic dout_warn_o,
  output logic relay_warn_o,
  output logic [dlw_pkg::FRQ_W-1:0] target_freq_o
);
  import dlw_pkg::*;

  logic [CUR_W-1:0] cur_low_q;
  logic [CUR_W-1:0] cur_high_q;
  logic cur_high_set_q;
  logic [FRQ_W-1:0] frq_low_q;
  logic [FRQ_W-1:0] frq_high_q;
  logic signed [FB_W-1:0] fb_low_q;
  logic signed [FB_W-1:0] fb_high_q;
  logic [FRQ_W-1:0] skip_bw_q;
  logic [FRQ_W-1:0] skip_a_q;
  logic [FRQ_W-1:0] skip_b_q;
  logic [1:0] range_q;
  logic [N_WARN-1:0] route_dout_q;
  logic [N_WARN-1:0] route_relay_q;
  logic [N_WARN-1:0] warn_q;
  logic [N_WARN-1:0] warn_d;
  dlw_phase_type phase_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [FRQ_W-1:0] target_q;
  logic [FRQ_W-1:0] target_d;
  logic dout_q;
  logic relay_q;
  logic [31:0] wmerged;
  logic [31:0] rmux;
  logic [CUR_W-1:0] cur_high_eff;
  logic [FRQ_W-1:0] frq_cap;
  logic [FRQ_W-1:0] half_bw;
  logic access;

  // Merge byte lanes of a write into an old word
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Clamp a frequency into a limit
  function automatic logic [FRQ_W-1:0] cap_frq(input logic [FRQ_W-1:0] v, input logic [FRQ_W-1:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // Push a reference out of one skip band to the nearer edge
  function automatic logic [FRQ_W-1:0] skip_band(input logic [FRQ_W-1:0] ref_v, input logic [FRQ_W-1:0] ctr,
                                                 input logic [FRQ_W-1:0] hb);
    logic [FRQ_W:0] lo;
    logic [FRQ_W:0] hi;
    logic [FRQ_W-1:0] r;
    lo = (ctr > hb) ? {1'b0, ctr - hb} : '0;
    hi = {1'b0, ctr} + {1'b0, hb};
    r = ref_v;
    if ({1'b0, ref_v} > lo && {1'b0, ref_v} < hi) begin
      if (({1'b0, ref_v} - lo) < (hi - {1'b0, ref_v})) begin
        r = lo[FRQ_W-1:0];
      end else begin
        r = (hi[FRQ_W] != 1'b0) ? '1 : hi[FRQ_W-1:0];
      end
    end
    return r;
  endfunction

  assign access = (avs_read_i | avs_write_i) & ~ack_q;
  assign wmerged = merge_be(rmux, avs_writedata_i, avs_byteenable_i);
  assign cur_high_eff = cur_high_set_q ? cur_high_q : current_max_i;
  assign frq_cap = range_q[1] ? FRQ_CAP_HIGH_RANGE : FRQ_CAP_LOW_RANGE;
  assign half_bw = {1'b0, skip_bw_q[FRQ_W-1:1]};

  // Read multiplexer over the register map
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (avs_address_i)
      OFS_CUR_LOW: rmux = {16'h0000, cur_low_q};
      OFS_CUR_HIGH: rmux = {16'h0000, cur_high_eff};
      OFS_FRQ_LOW: rmux = {16'h0000, frq_low_q};
      OFS_FRQ_HIGH: rmux = {16'h0000, frq_high_q};
      OFS_FB_LOW: rmux = {{(32-FB_W){fb_low_q[FB_W-1]}}, fb_low_q};
      OFS_FB_HIGH: rmux = {{(32-FB_W){fb_high_q[FB_W-1]}}, fb_high_q};
      OFS_SKIP_BW: rmux = {16'h0000, skip_bw_q};
      OFS_SKIP_A: rmux = {16'h0000, skip_a_q};
      OFS_SKIP_B: rmux = {16'h0000, skip_b_q};
      OFS_CONFIG: rmux = {30'h0000_0000, range_q};
      OFS_ROUTE_DOUT: rmux = {26'h000_0000, route_dout_q};
      OFS_ROUTE_RELAY: rmux = {26'h000_0000, route_relay_q};
      OFS_STATUS: rmux = {24'h00_0000, phase_q, warn_q};
      OFS_TARGET: rmux = {16'h0000, target_q};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // Bus handshake: one wait cycle, then acknowledge; waitrequest kept in its own flop
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= access;
      wait_q <= ~access;
      if (access && avs_read_i) begin
        rdata_q <= rmux;
      end
    end
  end

  // Threshold and configuration registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_low_q <= RST_CUR_LOW;
      cur_high_q <= CUR_MAX_DEFAULT;
      cur_high_set_q <= 1'b0;
      frq_low_q <= RST_FRQ_LOW;
      frq_high_q <= RST_FRQ_HIGH;
      fb_low_q <= RST_FB_LOW;
      fb_high_q <= RST_FB_HIGH;
      skip_bw_q <= RST_SKIP;
      skip_a_q <= RST_SKIP;
      skip_b_q <= RST_SKIP;
      range_q <= 2'h0;
      route_dout_q <= '0;
      route_relay_q <= '0;
    end else begin
      // Write lands only at the edge that completes the transfer
      if (avs_write_i && ack_q) begin
        unique case (avs_address_i)
          OFS_CUR_LOW: cur_low_q <= wmerged[CUR_W-1:0];
          OFS_CUR_HIGH: begin
            cur_high_q <= wmerged[CUR_W-1:0];
            cur_high_set_q <= 1'b1;
          end
          OFS_FRQ_LOW: frq_low_q <= wmerged[FRQ_W-1:0];
          OFS_FRQ_HIGH: frq_high_q <= cap_frq(wmerged[FRQ_W-1:0], frq_cap);
          OFS_FB_LOW: fb_low_q <= wmerged[FB_W-1:0];
          OFS_FB_HIGH: fb_high_q <= wmerged[FB_W-1:0];
          OFS_SKIP_BW: skip_bw_q <= cap_frq(wmerged[FRQ_W-1:0], SKIP_BW_MAX);
          OFS_SKIP_A: skip_a_q <= cap_frq(wmerged[FRQ_W-1:0], SKIP_CENTRE_MAX);
          OFS_SKIP_B: skip_b_q <= cap_frq(wmerged[FRQ_W-1:0], SKIP_CENTRE_MAX);
          OFS_CONFIG: range_q <= wmerged[CFG_RANGE_LSB +: 2];
          OFS_ROUTE_DOUT: route_dout_q <= wmerged[N_WARN-1:0];
          OFS_ROUTE_RELAY: route_relay_q <= wmerged[N_WARN-1:0];
          default: ;
        endcase
      end else if (!range_q[1] && frq_high_q > FRQ_CAP_LOW_RANGE) begin
        frq_high_q <= FRQ_CAP_LOW_RANGE;
      end
    end
  end

  // Run phase tracking on each control update
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= DLW_STOPPED;
    end else if (update_i) begin
      unique case (phase_q)
        DLW_STOPPED: if (drive_i.run) begin
          phase_q <= DLW_RAMP_UP;
        end
        DLW_RAMP_UP: begin
          if (!drive_i.run) begin
            phase_q <= DLW_RAMP_DOWN;
          end else if (meas_i.freq == target_q) begin
            phase_q <= DLW_AT_REF;
          end
        end
        DLW_AT_REF: begin
          if (!drive_i.run) begin
            phase_q <= DLW_RAMP_DOWN;
          end else if (target_d != target_q) begin
            phase_q <= DLW_RAMP_UP;
          end
        end
        DLW_RAMP_DOWN: begin
          if (drive_i.run) begin
            phase_q <= DLW_RAMP_UP;
          end else if (meas_i.freq == '0) begin
            phase_q <= DLW_STOPPED;
          end
        end
      endcase
    end
  end

  // Warning comparisons, gated by the phase
  always_comb begin
    warn_d = '0;
    // A stop command silences warnings at once, not one update later
    if (phase_q == DLW_AT_REF && drive_i.run) begin
      warn_d[W_CUR_LOW] = meas_i.current < cur_low_q;
      warn_d[W_CUR_HIGH] = meas_i.current > cur_high_eff;
      warn_d[W_FRQ_LOW] = meas_i.freq < frq_low_q;
      warn_d[W_FRQ_HIGH] = meas_i.freq > frq_high_q;
      warn_d[W_FB_LOW] = meas_i.feedback < fb_low_q;
      warn_d[W_FB_HIGH] = meas_i.feedback > fb_high_q;
    end
  end

  // Skip band clamp of the reference
  always_comb begin
    target_d = drive_i.reference;
    if (skip_bw_q != '0) begin
      target_d = skip_band(target_d, skip_a_q, half_bw);
      target_d = skip_band(target_d, skip_b_q, half_bw);
    end
  end

  // Warning flags and routed outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_q <= '0;
      dout_q <= 1'b0;
      relay_q <= 1'b0;
      target_q <= '0;
    end else if (update_i) begin
      warn_q <= warn_d;
      dout_q <= |(warn_d & route_dout_q);
      relay_q <= |(warn_d & route_relay_q);
      target_q <= target_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign warn_o = warn_q;
  assign dout_warn_o = dout_q;
  assign relay_warn_o = relay_q;
  assign target_freq_o = target_q;

endmodule

`default_nettype wire

// ---- bench/dlw_chk.sv ----
// Port checker for the limit warning block
`timescale 1ns/1ps
`default_nettype none
module dlw_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic update_i,
  input wire dlw_pkg::dlw_drive_type drive_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [dlw_pkg::N_WARN-1:0] warn_o,
  input wire logic dout_warn_o,
  input wire logic relay_warn_o,
  input wire logic [dlw_pkg::FRQ_W-1:0] target_freq_o
);
  import dlw_pkg::*;
  logic idle_q;
  logic req_w;
  // Any bus request pending
  assign req_w = avs_read_i || avs_write_i;
  // Last update saw the drive without a start command
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q <= 1'b1;
    end else if (update_i) begin
      idle_q <= !drive_i.run;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence req_taken_s;
    req_w && avs_waitrequest_o;
  endsequence
  sequence answer_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_ONE_WAIT: assert property (req_taken_s |=> answer_s)
    else $error("bus answer not after one wait state");
  AST_IDLE_WAIT: assert property (!req_w |=> avs_waitrequest_o)
    else $error("answer without request");
  AST_ANSWER_CAUSE: assert property ($fell(avs_waitrequest_o) |-> $past(req_w))
    else $error("answer not caused by a request");
  AST_RD_STAND: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  AST_WARN_HOLD: assert property (!update_i |=> $stable(warn_o))
    else $error("warnings moved without an update");
  AST_TGT_HOLD: assert property (!update_i |=> $stable(target_freq_o))
    else $error("target moved without an update");
  AST_QUIET: assert property (update_i && idle_q |=> warn_o == '0 && !dout_warn_o && !relay_warn_o)
    else $error("warning while stopped or starting");
  AST_STOP_QUIET: assert property (update_i && !drive_i.run |=> warn_o == '0 && !dout_warn_o && !relay_warn_o)
    else $error("warning on a stop update");
  AST_ROUTE_OFF: assert property ((warn_o == '0) [*2] |-> !dout_warn_o && !relay_warn_o)
    else $error("routed output without a warning");
endmodule
bind dlw_top dlw_chk u_chk (.core_clk_i, .rst_i, .update_i, .drive_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .avs_readdata_o, .warn_o, .dout_warn_o, .relay_warn_o, .target_freq_o);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the limit warning block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dlw_pkg::*;
  logic core_clk_i;
  logic rst_i;
  logic update_i;
  dlw_meas_type meas_i;
  dlw_drive_type drive_i;
  logic [CUR_W-1:0] current_max_i;
  logic [7:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [N_WARN-1:0] warn_o;
  logic dout_warn_o;
  logic relay_warn_o;
  logic [FRQ_W-1:0] target_freq_o;
  int failures;
  int comparisons;
  dlw_top uut (.core_clk_i, .rst_i, .update_i, .meas_i, .drive_i, .current_max_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .warn_o, .dout_warn_o, .relay_warn_o, .target_freq_o);
  // Clock at 40 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      failures++;
      $display("wrong value at %0t: bus timeout", $time);
      tally_and_finish();
    end else begin
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask
  // One control update; checks warnings and routing unless e is 6'h3f
  task automatic upd(input logic run, input logic [15:0] rf, input logic [15:0] cur, input logic [15:0] frq,
                     input logic signed [27:0] fb, input logic [5:0] e);
    meas_i <= '{cur, frq, fb};
    drive_i <= '{run, rf};
    update_i <= 1'b1;
    @(posedge core_clk_i);
    update_i <= 1'b0;
    @(posedge core_clk_i);
    if (e !== 6'h3f) chk({dout_warn_o, relay_warn_o, warn_o}, {|(e & 6'h01), |(e & 6'h20), e});
  endtask
  task automatic t_defaults();
    rd(OFS_CUR_LOW, 32'h0);
    rd(OFS_CUR_HIGH, 32'h320);
    rd(OFS_FRQ_LOW, 32'h0);
    rd(OFS_FRQ_HIGH, 32'h528);
    rd(OFS_FB_LOW, 32'hffc2f700);
    rd(OFS_FB_HIGH, 32'h003d0900);
    rd(OFS_SKIP_BW, 32'h0);
    rd(OFS_SKIP_A, 32'h0);
    rd(OFS_SKIP_B, 32'h0);
    rd(8'h3c, 32'h0);
  endtask
  task automatic t_warn();
    wr(OFS_CUR_LOW, 32'd100);
    wr(OFS_CUR_HIGH, 32'd200);
    wr(OFS_FRQ_LOW, 32'd1000);
    wr(OFS_FRQ_HIGH, 32'd1300);
    wr(OFS_FB_LOW, 32'hfffffff6);
    wr(OFS_FB_HIGH, 32'd10);
    wr(OFS_ROUTE_DOUT, 32'h01);
    wr(OFS_ROUTE_RELAY, 32'h20);
    upd(1'b1, 1200, 50, 0, 0, 6'h00);
    upd(1'b1, 1200, 50, 500, 0, 6'h00);
    upd(1'b1, 1200, 50, 1200, 0, 6'h00);
    chk(target_freq_o, 32'd1200);
    rd(OFS_STATUS, 32'h80);
    upd(1'b1, 1200, 50, 1200, 20, 6'h21);
    upd(1'b1, 1200, 300, 1200, -20, 6'h12);
    upd(1'b1, 1200, 150, 500, 0, 6'h04);
    upd(1'b1, 1200, 150, 1310, 0, 6'h08);
    upd(1'b1, 1200, 150, 1200, 0, 6'h00);
    upd(1'b0, 1200, 50, 1200, 0, 6'h00);
    upd(1'b0, 1200, 50, 600, 0, 6'h00);
  endtask
  task automatic t_skip();
    int r [6] = '{1020, 960, 1000, 950, 3010, 2990};
    int x [6] = '{1050, 950, 1050, 950, 3050, 2950};
    wr(OFS_SKIP_BW, 32'd100);
    wr(OFS_SKIP_A, 32'd1000);
    wr(OFS_SKIP_B, 32'd3000);
    for (int i = 0; i < 6; i++) begin
      upd(1'b1, 16'(r[i]), 150, 0, 0, 6'h3f);
      chk(target_freq_o, x[i]);
    end
    rd(OFS_TARGET, 32'd2950);
  endtask
  task automatic t_clamp();
    logic [31:0] q;
    wr(OFS_FRQ_HIGH, 32'h600);
    rd(OFS_FRQ_HIGH, 32'h528);
    wr(OFS_CONFIG, 32'h2);
    wr(OFS_FRQ_HIGH, 32'h3000);
    rd(OFS_FRQ_HIGH, 32'h2710);
    wr(OFS_CONFIG, 32'h3);
    rd(OFS_FRQ_HIGH, 32'h2710);
    wr(OFS_CONFIG, 32'h1);
    rd(OFS_FRQ_HIGH, 32'h528);
    wr(OFS_SKIP_BW, 32'h500);
    rd(OFS_SKIP_BW, 32'h3e8);
    wr(OFS_SKIP_B, 32'h3000);
    rd(OFS_SKIP_B, 32'h2710);
    bus(1'b1, OFS_CUR_LOW, 32'h0000ab00, 4'h2, q);
    rd(OFS_CUR_LOW, 32'hab64);
    wr(8'h3c, 32'h55);
    rd(8'h3c, 32'h0);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    failures = 0;
    comparisons = 0;
    rst_i = 1'b1;
    update_i = 1'b0;
    meas_i = '0;
    drive_i = '0;
    current_max_i = 16'h0320;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_defaults();
    t_warn();
    t_skip();
    t_clamp();
    tally_and_finish();
  end
endmodule
`default_nettype wire
